// ---- verilog/cni_top.v ----
// Comfort-noise insertion: noise measurement, level monitors and send output substitution
`timescale 1ns/1ps
`include "cni_defines.vh"
module cni_top (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire [7:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	input  wire        i_sample_tick,
	input  wire [15:0] i_send_in,
	input  wire [15:0] i_send_proc,
	input  wire [15:0] i_recv_in,
	input  wire        i_suppress_active,
	input  wire [7:0]  i_combined_loss,
	input  wire [7:0]  i_supp_threshold,
	output reg  [15:0] o_send_out,
	output reg         o_send_valid,
	output reg         o_measuring,
	output reg         o_unlocked
);
	// Magnitude of a two's-complement sample; -32768 gives 32768
	function [15:0] mag16;
		input [15:0] s;
		begin
			mag16 = s[15] ? (16'h0000 - s) : s;
		end
	endfunction

	// Used for the negative half of the send sample when limiting
	function send_mag_gt;
		input [15:0] s;
		input [15:0] lim;
		begin
			send_mag_gt = (mag16(s) > lim);
		end
	endfunction

	// Offset code to linear gain, unity at 100H, 1.5dB per code step
	function [10:0] offset_gain;
		input [3:0] code;
		begin
			case (code)
				4'h0:    offset_gain = 11'h080;
				4'h1:    offset_gain = 11'h098;
				4'h2:    offset_gain = 11'h0B5;
				4'h3:    offset_gain = 11'h0D7;
				4'h4:    offset_gain = `CNI_GAIN_UNITY;
				4'h5:    offset_gain = 11'h130;
				4'h6:    offset_gain = 11'h16A;
				4'h7:    offset_gain = 11'h1AE;
				4'h8:    offset_gain = 11'h1FF;
				4'h9:    offset_gain = 11'h260;
				4'hA:    offset_gain = 11'h2D4;
				4'hB:    offset_gain = 11'h35D;
				4'hC:    offset_gain = 11'h400;
				4'hD:    offset_gain = 11'h4C1;
				4'hE:    offset_gain = 11'h5A8;
				default: offset_gain = 11'h6BA;
			endcase
		end
	endfunction

	// Reset release through two flops
	// Asserts at once, releases on the clock so no flop leaves reset mid-edge
	reg        rst_meta_reg;
	reg        rst_sync_reg;
	wire       rst_n;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	// Configuration registers
	reg  [7:0]  tuning_reg;
	reg  [7:0]  ceilings_reg;
	reg  [7:0]  out_cfg_reg;
	reg  [7:0]  loss_mon_reg;
	reg  [7:0]  thresh_mon_reg;
	reg         unlock_next;
	wire        wr_unlock;
	wire        wr_protected;
	wire        wr_accept;

	assign wr_unlock    = i_wr && (i_addr == `CNI_ADDR_UNLOCK);
	assign wr_protected = i_wr && ((i_addr == `CNI_ADDR_TUNING) ||
	                               (i_addr == `CNI_ADDR_CEILINGS) ||
	                               (i_addr == `CNI_ADDR_OUT_CFG));
	assign wr_accept    = wr_protected && o_unlocked;

	// Unlock arms one protected write; any other unlock value disarms
	// Single use keeps a stray later write away from the protected registers
	always @* begin
		unlock_next = o_unlocked;
		if (wr_unlock)
			unlock_next = (i_wdata == `CNI_UNLOCK_CODE);
		else if (wr_protected)
			unlock_next = 1'b0;
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tuning_reg   <= `CNI_RST_TUNING;
			ceilings_reg <= `CNI_RST_CEILINGS;
			out_cfg_reg  <= `CNI_RST_OUT_CFG;
			o_unlocked   <= 1'b0;
		end else begin
			o_unlocked <= unlock_next;
			if (wr_accept && (i_addr == `CNI_ADDR_TUNING)) begin
				tuning_reg <= i_wdata;
			end
			if (wr_accept && (i_addr == `CNI_ADDR_CEILINGS)) begin
				ceilings_reg <= i_wdata;
			end
			if (wr_accept && (i_addr == `CNI_ADDR_OUT_CFG)) begin
				out_cfg_reg <= i_wdata;
			end
		end
	end

	// Field views
	wire [3:0]  level_offset;
	wire [1:0]  rise_step;
	wire [1:0]  fall_step;
	wire [3:0]  send_ceiling;
	wire [3:0]  recv_ceiling;
	wire        std_select;
	wire        std_variant;

	assign level_offset = tuning_reg[`CNI_OFFSET_MSB:`CNI_OFFSET_LSB];
	assign rise_step    = tuning_reg[`CNI_RISE_MSB:`CNI_RISE_LSB];
	assign fall_step    = tuning_reg[`CNI_FALL_MSB:`CNI_FALL_LSB];
	assign send_ceiling = ceilings_reg[`CNI_SEND_CEIL_MSB:`CNI_SEND_CEIL_LSB];
	assign recv_ceiling = ceilings_reg[`CNI_RECV_CEIL_MSB:`CNI_RECV_CEIL_LSB];
	assign std_select   = out_cfg_reg[`CNI_STD_SELECT_BIT];
	assign std_variant  = out_cfg_reg[`CNI_STD_VARIANT_BIT];

	// Full-scale input overflows the ceiling field, so it always counts as loud
	function over_ceiling;
		input [15:0] m;
		input [3:0]  ceil;
		begin
			over_ceiling = m[15] || (m[`CNI_MAG_CEIL_MSB:`CNI_MAG_CEIL_LSB] > ceil);
		end
	endfunction

	// Measurement gating
	wire [15:0] send_in_mag;
	wire [15:0] send_out_mag;
	wire [15:0] recv_mag;
	wire [15:0] louder_send;
	wire        send_over;
	wire        recv_over;
	wire        hold_meas;

	assign send_in_mag  = mag16(i_send_in);
	assign send_out_mag = mag16(o_send_out);
	assign recv_mag     = mag16(i_recv_in);
	assign louder_send  = (send_in_mag > send_out_mag) ? send_in_mag : send_out_mag;
	assign send_over    = over_ceiling(louder_send, send_ceiling);
	assign recv_over    = over_ceiling(recv_mag, recv_ceiling);
	assign hold_meas    = send_over || recv_over;

	// Background noise estimate
	wire [15:0] noise_est;

	cni_level_est u_level_est (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_tick  (i_sample_tick),
		.i_hold  (hold_meas),
		.i_mag   (send_in_mag),
		.i_rise  (rise_step),
		.i_fall  (fall_step),
		.o_est   (noise_est)
	);

	// Target comfort amplitude from estimate and offset
	wire [26:0] target_prod;
	wire        target_sat;
	wire [15:0] target_amp;

	assign target_prod = noise_est * offset_gain(level_offset);
	assign target_sat  = (target_prod[26:23] != 4'h0);
	// Saturate rather than wrap, so a loud estimate never flips the noise sign
	assign target_amp  = target_sat ? `CNI_AMP_MAX : {1'b0, target_prod[22:8]};

	// Noise source
	wire [15:0] noise_sample;

	cni_noise_gen u_noise_gen (
		.i_clk    (i_clk),
		.i_rst_n  (rst_n),
		.i_tick   (i_sample_tick),
		.i_band   (std_variant),
		.i_amp    (target_amp),
		.o_sample (noise_sample)
	);

	// Subjective limiting of the processed send sample
	wire [15:0] neg_target;
	wire        proc_above;
	wire        proc_below;
	wire [15:0] limited_sample;

	assign neg_target     = 16'h0000 - target_amp;
	assign proc_above     = !i_send_proc[15] && (i_send_proc > target_amp);
	assign proc_below     = i_send_proc[15] && (send_mag_gt(i_send_proc, target_amp));
	assign limited_sample = proc_above ? target_amp :
	                        proc_below ? neg_target : i_send_proc;

	// Send output selection
	reg  [15:0] send_next;

	always @* begin
		send_next = i_send_proc;
		if (i_suppress_active) begin
			if (std_select) begin
				if (std_variant)
					send_next = noise_sample;
				else
					send_next = 16'h0000;
			end else begin
				send_next = limited_sample;
			end
		end
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_send_out   <= 16'h0000;
			o_send_valid <= 1'b0;
			o_measuring  <= 1'b0;
		end else begin
			o_send_valid <= i_sample_tick;
			if (i_sample_tick) begin
				o_send_out  <= send_next;
				o_measuring <= !hold_meas;
			end
		end
	end

	// Monitors captured per sample so a read sees a consistent value
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			loss_mon_reg   <= 8'h00;
			thresh_mon_reg <= 8'h00;
		end else if (i_sample_tick) begin
			loss_mon_reg   <= i_combined_loss;
			thresh_mon_reg <= i_supp_threshold;
		end
	end

	// Read port; write-only and unmapped addresses read as zero
	reg  [7:0]  rdata_next;

	always @* begin
		rdata_next = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`CNI_ADDR_NOISE_MON:  rdata_next = noise_est[`CNI_MON_MSB:`CNI_MON_LSB];
				`CNI_ADDR_LOSS_MON:   rdata_next = loss_mon_reg;
				`CNI_ADDR_THRESH_MON: rdata_next = thresh_mon_reg;
				default:              rdata_next = 8'h00;
			endcase
		end
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= rdata_next;
		end
	end
endmodule // cni_top

// ---- verilog/cni_defines.vh ----
// Register map, field layout, reset values and constants of the comfort-noise block
`ifndef CNI_DEFINES_VH
`define CNI_DEFINES_VH

`define CNI_ADDR_UNLOCK       8'h01
`define CNI_ADDR_TUNING       8'h18
`define CNI_ADDR_CEILINGS     8'h19
`define CNI_ADDR_NOISE_MON    8'h24
`define CNI_ADDR_LOSS_MON     8'h26
`define CNI_ADDR_THRESH_MON   8'h27
`define CNI_ADDR_OUT_CFG      8'h30

`define CNI_UNLOCK_CODE       8'h95

`define CNI_RST_TUNING        8'h8A
`define CNI_RST_CEILINGS      8'hEE
`define CNI_RST_OUT_CFG       8'h03

`define CNI_OFFSET_MSB        7
`define CNI_OFFSET_LSB        4
`define CNI_RISE_MSB          3
`define CNI_RISE_LSB          2
`define CNI_FALL_MSB          1
`define CNI_FALL_LSB          0
`define CNI_SEND_CEIL_MSB     7
`define CNI_SEND_CEIL_LSB     4
`define CNI_RECV_CEIL_MSB     3
`define CNI_RECV_CEIL_LSB     0
`define CNI_STD_SELECT_BIT    1
`define CNI_STD_VARIANT_BIT   0

`define CNI_MAG_CEIL_MSB      14
`define CNI_MAG_CEIL_LSB      11
`define CNI_MON_MSB           14
`define CNI_MON_LSB           7
`define CNI_SHIFT_BASE        3'h7
`define CNI_GAIN_UNITY        11'h100
`define CNI_AMP_MAX           16'h7FFF
`define CNI_LFSR_SEED         16'hACE1

`endif

// ---- verilog/cni_level_est.v ----
// Background noise level estimator with separate rise and fall tracking
`timescale 1ns/1ps
`include "cni_defines.vh"
module cni_level_est (
	input  wire        i_clk,
	input  wire        i_rst_n,
	input  wire        i_tick,
	input  wire        i_hold,
	input  wire [15:0] i_mag,
	input  wire [1:0]  i_rise,
	input  wire [1:0]  i_fall,
	output reg  [15:0] o_est
);
	wire [2:0]  rise_shift;
	wire [2:0]  fall_shift;
	wire [15:0] up_diff;
	wire [15:0] dn_diff;
	reg  [15:0] est_next;

	// Bigger step means smaller shift, so faster but less stable tracking
	assign rise_shift = `CNI_SHIFT_BASE - {1'b0, i_rise};
	assign fall_shift = `CNI_SHIFT_BASE - {1'b0, i_fall};
	assign up_diff    = (i_mag - o_est) >> rise_shift;
	assign dn_diff    = (o_est - i_mag) >> fall_shift;

	always @* begin
		est_next = o_est;
		if (i_tick && !i_hold) begin
			if (i_mag > o_est)
				est_next = o_est + ((up_diff == 16'h0000) ? 16'h0001 : up_diff);
			else if (i_mag < o_est)
				est_next = o_est - ((dn_diff == 16'h0000) ? 16'h0001 : dn_diff);
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_est <= 16'h0000;
		else
			o_est <= est_next;
	end
endmodule // cni_level_est

// ---- verilog/cni_noise_gen.v ----
// Free-running pseudo-random source scaled to a constant target amplitude
`timescale 1ns/1ps
`include "cni_defines.vh"
module cni_noise_gen (
	input  wire        i_clk,
	input  wire        i_rst_n,
	input  wire        i_tick,
	input  wire        i_band,
	input  wire [15:0] i_amp,
	output wire [15:0] o_sample
);
	reg  [15:0] lfsr_reg;
	wire        feedback;
	wire        sign_white;
	wire        sign_band;
	wire        sign_sel;

	assign feedback = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];

	// Advances once per sample, never stalls, so the sequence keeps running
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			lfsr_reg <= `CNI_LFSR_SEED;
		else if (i_tick)
			lfsr_reg <= {lfsr_reg[14:0], feedback};
	end

	assign sign_white = lfsr_reg[0];
	// Majority of three recent bits lowers the bandwidth, amplitude stays constant
	assign sign_band  = (lfsr_reg[0] & lfsr_reg[1]) | (lfsr_reg[1] & lfsr_reg[2]) | (lfsr_reg[0] & lfsr_reg[2]);
	assign sign_sel   = i_band ? sign_band : sign_white;
	assign o_sample   = sign_sel ? (16'h0000 - i_amp) : i_amp;
endmodule // cni_noise_gen

// ---- testbench/cni_top_monitor.sv ----
// Port assertions for the comfort-noise block
`timescale 1ns/1ps
module cni_monitor (
	input wire        i_clk,
	input wire        i_reset_n,
	input wire [7:0]  i_addr,
	input wire [7:0]  i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [7:0]  o_rdata,
	input wire        i_sample_tick,
	input wire [15:0] i_send_in,
	input wire [15:0] i_send_proc,
	input wire [15:0] i_recv_in,
	input wire        i_suppress_active,
	input wire [15:0] o_send_out,
	input wire        o_send_valid,
	input wire        o_measuring,
	input wire        o_unlocked
);
	wire [15:0] smag = i_send_in[15] ? -i_send_in : i_send_in;
	wire [15:0] rmag = i_recv_in[15] ? -i_recv_in : i_recv_in;
	wire [15:0] omag = o_send_out[15] ? -o_send_out : o_send_out;
	wire        prot = i_wr && (i_addr == 8'h18 || i_addr == 8'h19 || i_addr == 8'h30);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside its slot");
	pass_through_a: assert property (i_sample_tick && !i_suppress_active |=> o_send_valid &&
		o_send_out == $past(i_send_proc)) else $error("send path not passed");
	out_stands_a: assert property (!i_sample_tick |=> $stable(o_send_out) && $stable(o_measuring))
		else $error("output moved between frames");
	// Full-scale levels exceed any ceiling up to E, which this bench never raises
	send_hold_a: assert property (i_sample_tick && smag[15:11] == 5'h0F |=> !o_measuring)
		else $error("loud send kept measuring");
	recv_hold_a: assert property (i_sample_tick && rmag[15:11] == 5'h0F |=> !o_measuring)
		else $error("loud receive kept measuring");
	quiet_measure_a: assert property (i_sample_tick && smag[15:11] == 5'h00 && rmag[15:11] == 5'h00
		&& omag[15:11] == 5'h00 |=> o_measuring) else $error("quiet frame not measured");
	unlock_arm_a: assert property (i_wr && i_addr == 8'h01 && i_wdata == 8'h95 |=> o_unlocked)
		else $error("unlock code not armed");
	unlock_once_a: assert property (o_unlocked && prot |=> !o_unlocked)
		else $error("unlock reused");
endmodule // cni_monitor
bind cni_top cni_monitor u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample_tick(i_sample_tick), .i_send_in(i_send_in),
	.i_send_proc(i_send_proc), .i_recv_in(i_recv_in), .i_suppress_active(i_suppress_active),
	.o_send_out(o_send_out), .o_send_valid(o_send_valid), .o_measuring(o_measuring), .o_unlocked(o_unlocked));

// ---- testbench/cni_pcm_source.sv ----
// Far-side sample source: frame ticks with alternating-sign send and receive samples
`timescale 1ns/1ps
module cni_pcm_source (
	input  wire        i_clk,
	input  wire        i_run,
	input  wire [15:0] i_send_mag,
	input  wire [15:0] i_recv_mag,
	output reg         o_tick,
	output reg  [15:0] o_send_in,
	output reg  [15:0] o_recv_in
);
	reg [2:0] cnt_reg = 3'h0;
	reg       sign_reg = 1'b0;
	initial begin
		o_tick = 1'b0;
		o_send_in = 16'h0000;
		o_recv_in = 16'h0000;
	end
	always @(posedge i_clk) begin
		cnt_reg <= cnt_reg + 3'h1;
		o_tick <= i_run && cnt_reg == 3'h7;
		if (i_run && cnt_reg == 3'h7) begin
			sign_reg <= ~sign_reg;
			o_send_in <= sign_reg ? -i_send_mag : i_send_mag;
			o_recv_in <= sign_reg ? -i_recv_mag : i_recv_mag;
		end else begin
			// Samples are only valid in the tick cycle; toggle so stale use shows
			o_send_in <= ~o_send_in;
			o_recv_in <= ~o_recv_in;
		end
	end
endmodule // cni_pcm_source

// ---- testbench/tb_top.sv ----
// Self-checking bench for the comfort-noise block
`timescale 1ns/1ps
module tb_top;
	reg         i_clk = 1'b0;
	reg         i_reset_n = 1'b0;
	reg  [7:0]  i_addr = 8'h00;
	reg  [7:0]  i_wdata = 8'h00;
	reg         i_wr = 1'b0;
	reg         i_rd = 1'b0;
	reg  [15:0] i_send_proc = 16'h0000;
	reg         i_suppress_active = 1'b0;
	reg  [7:0]  i_combined_loss = 8'h00;
	reg  [7:0]  i_supp_threshold = 8'h00;
	reg         run = 1'b0;
	reg  [15:0] send_mag = 16'h0000;
	reg  [15:0] recv_mag = 16'h0000;
	wire        tick;
	wire [15:0] send_in;
	wire [15:0] recv_in;
	wire [7:0]  o_rdata;
	wire [15:0] o_send_out;
	wire        o_send_valid;
	wire        o_measuring;
	wire        o_unlocked;
	integer     num_errors = 0;
	integer     num_checks = 0;
	always #4 i_clk = ~i_clk;
	cni_pcm_source u_src (.i_clk(i_clk), .i_run(run), .i_send_mag(send_mag), .i_recv_mag(recv_mag),
		.o_tick(tick), .o_send_in(send_in), .o_recv_in(recv_in));
	cni_top u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_sample_tick(tick), .i_send_in(send_in), .i_send_proc(i_send_proc),
		.i_recv_in(recv_in), .i_suppress_active(i_suppress_active), .i_combined_loss(i_combined_loss),
		.i_supp_threshold(i_supp_threshold), .o_send_out(o_send_out), .o_send_valid(o_send_valid),
		.o_measuring(o_measuring), .o_unlocked(o_unlocked));
	function [15:0] mag(input [15:0] v);
		mag = v[15] ? -v : v;
	endfunction
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk("read data", {8'h00, e}, {8'h00, o_rdata});
	endtask
	task unlock_wr(input logic [7:0] a, input logic [7:0] d);
		wr(8'h01, 8'h95);
		wr(a, d);
	endtask
	task smp;
		integer n;
		n = 0;
		@(negedge i_clk);
		while (o_send_valid !== 1'b1 && n < 50) begin
			@(negedge i_clk);
			n = n + 1;
		end
		chk("sample valid", 16'h0001, {15'h0, o_send_valid});
	endtask
	// Two frames, as the first may straddle the change
	task lvl(input logic [15:0] s, input logic [15:0] r, input logic [15:0] p);
		@(posedge i_clk);
		send_mag <= s;
		recv_mag <= r;
		i_send_proc <= p;
		smp;
		smp;
	endtask
	task noise(input logic [15:0] t);
		integer i;
		logic pos;
		logic neg;
		pos = 1'b0;
		neg = 1'b0;
		smp;
		for (i = 0; i < 8; i = i + 1) begin
			smp;
			chk("noise magnitude", t, mag(o_send_out));
			pos = pos | ~o_send_out[15];
			neg = neg | o_send_out[15];
		end
		chk("noise signs", 16'h0003, {14'h0, pos, neg});
	endtask
	task t_bus;
		@(posedge i_clk);
		i_combined_loss <= 8'h5A;
		i_supp_threshold <= 8'hC3;
		lvl(16'h0000, 16'h0000, 16'h1234);
		chk("pass-through", 16'h1234, o_send_out);
		rd(8'h26, 8'h5A);
		rd(8'h27, 8'hC3);
		wr(8'h27, 8'h00);
		rd(8'h27, 8'hC3);
		rd(8'h18, 8'h00);
		rd(8'h7E, 8'h00);
		rd(8'h24, 8'h00);
	endtask
	task t_measure;
		integer i;
		lvl(16'h0400, 16'h0000, 16'h1234);
		for (i = 0; i < 200; i = i + 1)
			smp;
		rd(8'h24, 8'h08);
		lvl(16'h7800, 16'h0000, 16'h1234);
		chk("measuring", 16'h0000, {15'h0, o_measuring});
		rd(8'h24, 8'h08);
		lvl(16'h0400, 16'h7800, 16'h1234);
		chk("measuring", 16'h0000, {15'h0, o_measuring});
		rd(8'h24, 8'h08);
		lvl(16'h0400, 16'h0C00, 16'h0100);
		unlock_wr(8'h19, 8'hE0);
		lvl(16'h0400, 16'h0C00, 16'h0100);
		chk("measuring", 16'h0000, {15'h0, o_measuring});
		unlock_wr(8'h19, 8'h0E);
		lvl(16'h0C00, 16'h0000, 16'h0100);
		chk("measuring", 16'h0000, {15'h0, o_measuring});
		lvl(16'h0400, 16'h0000, 16'h0100);
		unlock_wr(8'h19, 8'hEE);
		lvl(16'h0400, 16'h0000, 16'h0100);
		chk("measuring", 16'h0001, {15'h0, o_measuring});
		rd(8'h24, 8'h08);
	endtask
	task t_modes;
		@(posedge i_clk);
		i_suppress_active <= 1'b1;
		noise(16'h07FC);
		wr(8'h30, 8'h02);
		noise(16'h07FC);
		wr(8'h01, 8'h95);
		@(negedge i_clk);
		chk("unlock", 16'h0001, {15'h0, o_unlocked});
		wr(8'h30, 8'h02);
		lvl(16'h0400, 16'h0000, 16'h0100);
		chk("dead line", 16'h0000, o_send_out);
		wr(8'h30, 8'h03);
		lvl(16'h0400, 16'h0000, 16'h0100);
		chk("dead line", 16'h0000, o_send_out);
		unlock_wr(8'h30, 8'h03);
		unlock_wr(8'h18, 8'h2A);
		noise(16'h02D4);
		unlock_wr(8'h18, 8'h4A);
		noise(16'h0400);
		unlock_wr(8'h18, 8'h8A);
		unlock_wr(8'h30, 8'h00);
		lvl(16'h0400, 16'h0000, 16'h7FFF);
		chk("limited output", 16'h07FC, o_send_out);
		lvl(16'h0400, 16'h0000, 16'h8001);
		chk("limited output", 16'hF804, o_send_out);
		lvl(16'h0400, 16'h0000, 16'h0100);
		chk("limited output", 16'h0100, o_send_out);
	endtask
	task conclude;
		$display("checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		run <= 1'b1;
		t_bus;
		t_measure;
		t_modes;
		conclude;
	end
	// About 2200 cycles expected; generous margin
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors = num_errors + 1;
		conclude;
	end
endmodule // tb_top
